// File: core/rsp_pkg.sv
/*
 * shared constants and types of the supply, reset and oscillator
 * compensation supervisor: timing, register map, field layouts.
 * assumes a single 10 MHz clock and a 32-bit axi4-lite register bus.
 */
package rsp_pkg;
    // clock and the 1 ms enable tick derived from it
    localparam int RSP_CLK_HZ = 10_000_000;
    localparam int RSP_TICK_HZ = 1000;
    localparam int RSP_TICK_CYC = RSP_CLK_HZ / RSP_TICK_HZ;
    // times in their own unit, counted in 1 ms ticks
    localparam int RSP_REC_DELAY_MS = 300;
    localparam int RSP_PUSHBUTTON_DEBOUNCE_TIME_MS = 250;
    localparam int RSP_RST_PULSE_MS = 250;
    localparam int RSP_TEMP_PERIOD_S = 64;
    localparam int RSP_TEMP_PERIOD_MS = RSP_TEMP_PERIOD_S * 1000;
    // square wave half periods in clock cycles (shortest first, rounded down)
    localparam int RSP_HALF_32K = RSP_CLK_HZ / (2 * 32768);
    localparam int RSP_HALF_8K = RSP_CLK_HZ / (2 * 8192);
    localparam int RSP_HALF_4K = RSP_CLK_HZ / (2 * 4096);
    localparam int RSP_HALF_1HZ = RSP_CLK_HZ / 2;
    // register byte offsets
    localparam logic [7:0] RSP_OFS_CTRL = 8'h00;
    localparam logic [7:0] RSP_OFS_AGING = 8'h04;
    localparam logic [7:0] RSP_OFS_STATUS = 8'h08;
    localparam logic [7:0] RSP_OFS_CAP = 8'h0C;
    localparam logic [7:0] RSP_OFS_ISTAT = 8'h10;
    localparam logic [7:0] RSP_OFS_ICLR = 8'h14;
    localparam logic [7:0] RSP_OFS_IEN = 8'h18;
    // control register layout, bit 5 downward to bit 0
    typedef struct packed {
        logic alarm2_en;
        logic alarm1_en;
        logic osc_disable_n;
        logic wave_rate_sel_hi;
        logic wave_rate_sel_lo;
        logic irq_or_wave_select;
    } rsp_ctrl_t;
    localparam rsp_ctrl_t RSP_CTRL_RST = 6'h01;
    localparam int RSP_CTRL_CONV_BIT = 6;
    // supply status carried to the status register
    typedef struct packed {
        logic rtc_ok;
        logic nv_ok;
        logic on_backup;
    } rsp_supply_t;
    // event bits of the interrupt registers
    localparam int RSP_EV_ALM1 = 0;
    localparam int RSP_EV_ALM2 = 1;
    localparam int RSP_EV_PFAIL = 2;
    localparam int RSP_EV_PUSH = 3;
    localparam int RSP_EV_CONV = 4;
    localparam int RSP_EV_W = 5;
    // lookup table centre and reset values
    localparam logic [7:0] RSP_CAP_CENTRE = 8'h7F;
    localparam logic signed [8:0] RSP_TEMP_TURN = 9'sh019;
    localparam logic [7:0] RSP_AGING_RST = 8'h00;
    localparam logic [7:0] RSP_CAP_RST = 8'h7F;
    localparam logic [1:0] RSP_RESP_OKAY = 2'h0;
    localparam logic [1:0] RSP_RESP_SLVERR = 2'h2;
endpackage

// File: core/rsp_supervisor.sv
/*
 * supply select, reset pin supervisor with pushbutton, interrupt or
 * square wave output and compensated oscillator update scheduling,
 * with an axi4-lite register slave.
 * assumes comparator outputs and the reset pin are asynchronous; alarm
 * matches and the temperature sensor run on mclk.
 */
// Functional notes
// R1 - select bit 0: multifunction output carries square wave at chosen rate
// R2 - select bit 1: output low on enabled alarm match
// R3 - after power-up select bit is 1 and both alarms disabled
// R4 - reset pin pulled low while supply is below power-fail threshold
// R5 - reset released after supply held valid for the recovery interval
// R6 - reset pin also watched as a debounced pushbutton input
// R7 - oscillator disabled: skip recovery delay, release reset at once
// R8 - capacitance = lookup of temperature plus signed aging offset
// R9 - capacitance loads only on temperature change or user conversion end
// R10 - measure temperature at power-up and every 64 seconds on any supply
// R11 - backup supply used only when main below threshold and backup
// R12 - nonvolatile access allowed only while main above threshold
// R13 - clock/calendar access stays available on either supply
// R14 - host must not touch memory below minimum supply; not blocked
// R15 - pushbutton edge: debounce low, await release, full reset pulse
// R16 - supply return: hold reset for the recovery interval
// R17 - comparator and pin samples synchronised before use
`timescale 1ns/1ps
module rsp_supervisor
    import rsp_pkg::*;
#(
    parameter int P_TICK_CYC = RSP_TICK_CYC,
    parameter int P_HALF_1HZ = RSP_HALF_1HZ,
    parameter int P_REC_MS = RSP_REC_DELAY_MS,
    parameter int P_PUSHBUTTON_DEBOUNCE_TIME_MS = RSP_PUSHBUTTON_DEBOUNCE_TIME_MS,
    parameter int P_RST_MS = RSP_RST_PULSE_MS,
    parameter int P_TEMP_MS = RSP_TEMP_PERIOD_MS
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic vcc_above_pf,
    input wire logic vcc_above_bat,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    output logic irq_wave_out_n,
    output logic irq_wave_oe_n,
    input wire logic alarm1_match,
    input wire logic alarm2_match,
    input wire logic signed [7:0] temp_value,
    input wire logic temp_done,
    output logic conv_start,
    output logic [7:0] cap_sel,
    output logic on_backup,
    output logic nv_access_en,
    output logic rtc_access_en,
    output logic irq
);
    typedef enum logic [2:0] {
        RS_PWR_FAIL, RS_RECOVER, RS_RUN, RS_PB_DEBOUNCE, RS_PB_WAIT,
        RS_PB_PULSE
    } rsp_rst_state_t;

    localparam int NSYNC = 3;
    localparam logic [NSYNC-1:0] SYNC_RST = 3'h4;

    logic [NSYNC-1:0] sync_in, sync_out;
    logic pf_s, bat_s, pin_s, pin_prev_reg, pf_prev_reg, pin_fell, ms_tick;
    logic [23:0] tick_cnt_reg, half_cnt_reg, half_len;
    logic [15:0] rs_cnt_reg;
    logic [16:0] temp_cnt_reg;
    logic wave_reg, conv_busy_reg, conv_user_reg, user_req_reg;
    logic cap_load;
    logic [7:0] aging_reg, last_temp_reg;
    rsp_rst_state_t rs_state, rs_next;
    rsp_ctrl_t ctrl_reg;
    rsp_supply_t supply;
    logic [RSP_EV_W-1:0] istat_reg, ien_reg, ev, iclr;
    logic aw_full_reg, w_full_reg, wr_fire, rd_fire;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    // register index decode, shared by the write and read paths
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        case (a)
            RSP_OFS_CTRL: reg_index = 3'h1;
            RSP_OFS_AGING: reg_index = 3'h2;
            RSP_OFS_STATUS: reg_index = 3'h3;
            RSP_OFS_CAP: reg_index = 3'h4;
            RSP_OFS_ISTAT: reg_index = 3'h5;
            RSP_OFS_ICLR: reg_index = 3'h6;
            RSP_OFS_IEN: reg_index = 3'h7;
            default: reg_index = 3'h0;
        endcase
    endfunction

    // capacitance code: centre less a parabola around the turnover point
    function automatic logic [7:0] cap_lookup(input logic signed [7:0] t);
        logic signed [8:0] d;
        logic [17:0] sq;
        d = 9'(t) - RSP_TEMP_TURN;
        sq = 18'(d * d);
        if (sq[17:5] > 13'(RSP_CAP_CENTRE))
            cap_lookup = 8'h00;
        else
            cap_lookup = RSP_CAP_CENTRE - sq[12:5];
    endfunction

    // comparator outputs and reset pin cross in through two flops
    assign sync_in = {rst_pin_in, vcc_above_bat, vcc_above_pf}; // R17
    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            rsp_sync2 #(.RST_VAL(SYNC_RST[i])) u_sync (
                .mclk(mclk),
                .rst_b(rst_b),
                .d_async(sync_in[i]),
                .q_sync(sync_out[i])
            );
        end
    endgenerate
    assign pf_s = sync_out[0];
    assign bat_s = sync_out[1];
    assign pin_s = sync_out[2];

    // 1 ms enable tick
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_reg <= 24'h000000;
        end else if (tick_cnt_reg == 24'(P_TICK_CYC - 1)) begin
            tick_cnt_reg <= 24'h000000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 24'h000001;
        end
    end
    assign ms_tick = (tick_cnt_reg == 24'(P_TICK_CYC - 1));

    // edge detectors on the synchronised levels
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_prev_reg <= 1'b1;
            pf_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= pin_s;
            pf_prev_reg <= pf_s;
        end
    end
    assign pin_fell = pin_prev_reg && !pin_s && (rs_state == RS_RUN); // R6

    // reset sequencer next state; power fail overrides everything
    always_comb begin
        rs_next = rs_state;
        if (!pf_s) begin
            rs_next = RS_PWR_FAIL; // R4
        end else begin
            case (rs_state)
                RS_PWR_FAIL: rs_next = ctrl_reg.osc_disable_n ?
                    RS_RUN : RS_RECOVER; // R7 R16
                RS_RECOVER: if (ms_tick && rs_cnt_reg == 16'(P_REC_MS - 1))
                    rs_next = RS_RUN; // R5
                RS_RUN: if (pin_fell)
                    rs_next = RS_PB_DEBOUNCE; // R15
                RS_PB_DEBOUNCE: if (ms_tick &&
                    rs_cnt_reg == 16'(P_PUSHBUTTON_DEBOUNCE_TIME_MS - 1))
                    rs_next = RS_PB_WAIT;
                RS_PB_WAIT: if (pin_s)
                    rs_next = RS_PB_PULSE; // R15
                RS_PB_PULSE: if (ms_tick && rs_cnt_reg == 16'(P_RST_MS - 1))
                    rs_next = RS_RUN;
                default: rs_next = RS_PWR_FAIL;
            endcase
        end
    end

    // sequencer state, interval counter and pin drive
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rs_state <= RS_PWR_FAIL;
            rs_cnt_reg <= 16'h0000;
            rst_pin_oe_n <= 1'b0;
            rst_pin_out <= 1'b0;
        end else begin
            rs_state <= rs_next;
            if (rs_next != rs_state)
                rs_cnt_reg <= 16'h0000;
            else if (ms_tick)
                rs_cnt_reg <= rs_cnt_reg + 16'h0001;
            // pull-down off only while running or watching for release
            rst_pin_oe_n <= (rs_next == RS_RUN) ||
                (rs_next == RS_PB_WAIT); // R4 R5
            rst_pin_out <= 1'b0;
        end
    end

    // supply selection and access gating
    always_comb begin
        supply.on_backup = !pf_s && !bat_s; // R11
        supply.nv_ok = pf_s; // R12
        supply.rtc_ok = 1'b1; // R13
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            on_backup <= 1'b0;
            nv_access_en <= 1'b0;
            rtc_access_en <= 1'b1;
        end else begin
            on_backup <= supply.on_backup;
            nv_access_en <= supply.nv_ok;
            rtc_access_en <= supply.rtc_ok;
        end
    end

    // square wave divider, rate chosen by the two select bits
    always_comb begin
        case ({ctrl_reg.wave_rate_sel_hi, ctrl_reg.wave_rate_sel_lo})
            2'h0: half_len = 24'(P_HALF_1HZ);
            2'h1: half_len = 24'(RSP_HALF_4K);
            2'h2: half_len = 24'(RSP_HALF_8K);
            default: half_len = 24'(RSP_HALF_32K);
        endcase
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            half_cnt_reg <= 24'h000000;
            wave_reg <= 1'b1;
        end else if (half_cnt_reg >= half_len - 24'h000001) begin
            half_cnt_reg <= 24'h000000;
            wave_reg <= !wave_reg;
        end else begin
            half_cnt_reg <= half_cnt_reg + 24'h000001;
        end
    end

    // multifunction open-drain output: wave or alarm interrupt
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_wave_oe_n <= 1'b1; // R3
            irq_wave_out_n <= 1'b0;
        end else begin
            irq_wave_out_n <= 1'b0;
            if (!ctrl_reg.irq_or_wave_select)
                irq_wave_oe_n <= wave_reg; // R1
            else
                irq_wave_oe_n <= !((istat_reg[RSP_EV_ALM1] &&
                    ctrl_reg.alarm1_en) || (istat_reg[RSP_EV_ALM2] &&
                    ctrl_reg.alarm2_en)); // R2
        end
    end

    // conversion scheduler: at power-up, every period, or on request
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            temp_cnt_reg <= 17'h00000;
            conv_start <= 1'b1; // R10
            conv_busy_reg <= 1'b1;
            conv_user_reg <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            if (ms_tick)
                temp_cnt_reg <= (temp_cnt_reg == 17'(P_TEMP_MS - 1)) ?
                    17'h00000 : temp_cnt_reg + 17'h00001;
            if (temp_done)
                conv_busy_reg <= 1'b0;
            else if (!conv_busy_reg && (user_req_reg || (ms_tick &&
                temp_cnt_reg == 17'(P_TEMP_MS - 1)))) begin
                conv_start <= 1'b1; // R10
                conv_busy_reg <= 1'b1;
                conv_user_reg <= user_req_reg;
            end
        end
    end

    // capacitance update only on a new temperature or user conversion
    assign cap_load = temp_done && (conv_user_reg ||
        (temp_value != last_temp_reg)); // R9
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cap_sel <= RSP_CAP_RST;
            last_temp_reg <= 8'h00;
        end else if (cap_load) begin
            cap_sel <= 8'(sat_add(cap_lookup(temp_value), aging_reg)); // R8
            last_temp_reg <= temp_value;
        end
    end

    // lookup plus signed aging, clamped to the code range
    function automatic logic [7:0] sat_add(input logic [7:0] c,
                                           input logic [7:0] a);
        logic signed [9:0] s;
        s = $signed({2'h0, c}) + $signed({{2{a[7]}}, a});
        if (s < 0)
            sat_add = 8'h00;
        else if (s > 10'sh0FF)
            sat_add = 8'hFF;
        else
            sat_add = s[7:0];
    endfunction

    // sticky events; a new event wins over a clear in the same cycle
    assign ev = {temp_done, (rs_state == RS_RUN) && pin_fell,
        pf_prev_reg && !pf_s, alarm2_match, alarm1_match};
    assign iclr = (wr_fire && reg_index(aw_addr_reg) == 3'h6 &&
        w_strb_reg[0]) ? w_data_reg[RSP_EV_W-1:0] : '0;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            istat_reg <= '0;
            irq <= 1'b0;
        end else begin
            istat_reg <= (istat_reg & ~iclr) | ev;
            irq <= |(((istat_reg & ~iclr) | ev) & ien_reg);
        end
    end

    // write channel: address and data taken in either order
    assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RSP_RESP_OKAY;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                s_axi_wready <= 1'b0;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (reg_index(aw_addr_reg) == 3'h0) ?
                    RSP_RESP_SLVERR : RSP_RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // writable registers, low byte lane only
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= RSP_CTRL_RST; // R3
            aging_reg <= RSP_AGING_RST;
            ien_reg <= '0;
            user_req_reg <= 1'b0;
        end else begin
            if (conv_start)
                user_req_reg <= 1'b0;
            if (wr_fire && w_strb_reg[0]) begin
                case (reg_index(aw_addr_reg))
                    3'h1: begin
                        ctrl_reg <= w_data_reg[5:0];
                        if (w_data_reg[RSP_CTRL_CONV_BIT])
                            user_req_reg <= 1'b1;
                    end
                    3'h2: aging_reg <= w_data_reg[7:0];
                    3'h7: ien_reg <= w_data_reg[RSP_EV_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // read channel: data one cycle after the address is taken
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RSP_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RSP_RESP_OKAY;
            case (reg_index(s_axi_araddr))
                3'h1: s_axi_rdata <= {26'h0, ctrl_reg};
                3'h2: s_axi_rdata <= {24'h0, aging_reg};
                3'h3: s_axi_rdata <= {27'h0, !rst_pin_oe_n, conv_busy_reg,
                    rtc_access_en, nv_access_en, on_backup};
                3'h4: s_axi_rdata <= {16'h0, last_temp_reg, cap_sel};
                3'h5: s_axi_rdata <= {27'h0, istat_reg};
                3'h7: s_axi_rdata <= {27'h0, ien_reg};
                3'h6: s_axi_rdata <= 32'h00000000;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RSP_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_pfail_pulls_low: assert property (!pf_s |=> !rst_pin_oe_n) // R4
        else $error("reset pin not driven low on power fail");
    a_recover_holds: assert property (rs_state == RS_PWR_FAIL && pf_s &&
        !ctrl_reg.osc_disable_n |=> rs_state == RS_RECOVER &&
        !rst_pin_oe_n) // R16
        else $error("supply return did not enter recovery");
    a_osc_bypass: assert property (rs_state == RS_PWR_FAIL && pf_s &&
        ctrl_reg.osc_disable_n |=> rst_pin_oe_n) // R7
        else $error("recovery not bypassed with oscillator off");
    a_recover_release: assert property (rs_state == RS_RECOVER && pf_s &&
        ms_tick && rs_cnt_reg == 16'(P_REC_MS - 1) |=> rst_pin_oe_n) // R5
        else $error("reset not released after recovery interval");
    a_push_debounce: assert property (pin_fell && pf_s |=>
        rs_state == RS_PB_DEBOUNCE ##0 !rst_pin_oe_n) // R15
        else $error("pushbutton edge not debounced");
    a_backup_select: assert property ($past(rst_b) |-> on_backup ==
        $past(!pf_s && !bat_s)) // R11
        else $error("supply selection wrong");
    a_alarm_irq_pin: assert property (ctrl_reg.irq_or_wave_select &&
        ctrl_reg.alarm1_en && istat_reg[RSP_EV_ALM1] |=>
        !irq_wave_oe_n) // R2
        else $error("enabled alarm did not assert output");
    a_wave_follows: assert property (!ctrl_reg.irq_or_wave_select |=>
        irq_wave_oe_n == $past(wave_reg)) // R1
        else $error("square wave not on output");
    a_cap_only_load: assert property ($changed(cap_sel) |->
        $past(cap_load)) // R9
        else $error("capacitance changed without a load event");
    a_period_conv: assert property (!conv_busy_reg && !temp_done &&
        ms_tick && temp_cnt_reg == 17'(P_TEMP_MS - 1) |=> conv_start) // R10
        else $error("periodic conversion not started");

    c_push_cycle: cover property (rs_state == RS_PB_WAIT ##1
        rs_state == RS_PB_PULSE);
    c_backup: cover property (on_backup ##1 !on_backup);
    c_cap_load: cover property (cap_load && conv_user_reg);
    c_wave_mode: cover property (!ctrl_reg.irq_or_wave_select &&
        $rose(irq_wave_oe_n));
endmodule

// File: core/rsp_sync2.sv
/*
 * two flip-flop level synchroniser for one asynchronous input.
 * assumes the input is a slow level from a pin or comparator.
 */
`timescale 1ns/1ps
module rsp_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic d_async,
    output logic q_sync
);
    logic meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= RST_VAL;
            q_sync <= RST_VAL;
        end else begin
            meta_reg <= d_async;
            q_sync <= meta_reg;
        end
    end
endmodule

// File: sim/rsp_host.sv
/* host model on the reset and interrupt lines.
   assumes pins are open drain with pull-ups. */
`timescale 1ns/1ps
module rsp_host (
    input wire logic rst_pin_oe_n,
    input wire logic irq_wave_oe_n,
    input wire logic press,
    output logic rst_pin_in,
    output logic irq_n
);
    // wire levels: pulled up unless the device or the button pulls low
    assign rst_pin_in = rst_pin_oe_n & ~press;
    assign irq_n = irq_wave_oe_n;
endmodule

// File: sim/rsp_supervisor_bench.sv
/* bench for the supervisor: bus tasks, supply table, hand tests.
   assumes shortened timing parameters. */
`timescale 1ns/1ps
module rsp_supervisor_bench;
    import rsp_pkg::*;
    logic mclk = 0, rst_b = 0, press = 0, irq_n, last;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, cap_sel;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic vcc_above_pf = 1, vcc_above_bat = 1, rst_pin_in, rst_pin_out;
    logic rst_pin_oe_n, irq_wave_out_n, irq_wave_oe_n, alarm1_match = 0;
    logic alarm2_match = 0, temp_done = 0, conv_start, on_backup;
    logic nv_access_en, rtc_access_en, irq;
    logic signed [7:0] temp_value = 8'sh19;
    int err_count = 0, total_checks = 0, n;
    int halves [4] = '{20, RSP_HALF_4K, RSP_HALF_8K, RSP_HALF_32K};
    // rows: above threshold, above backup, backup, memory access
    logic [3:0] rows [4] = '{4'b0010, 4'b0100, 4'b1101, 4'b1001};
    rsp_supervisor #(.P_TICK_CYC(10), .P_HALF_1HZ(20), .P_REC_MS(3),
        .P_PUSHBUTTON_DEBOUNCE_TIME_MS(3), .P_RST_MS(3), .P_TEMP_MS(5)) dut (.*);
    rsp_host host (.*);
    initial forever #50 mclk = ~mclk;
    // sensor answers each conversion request three cycles later
    always @(posedge mclk) if (conv_start) begin
        repeat (3) @(posedge mclk);
        temp_done <= 1;
        @(posedge mclk);
        temp_done <= 0;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            rsp = s_axi_bresp;
        end while (!s_axi_bvalid);
    endtask
    task rd_reg(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
        end while (!s_axi_rvalid);
    endtask
    task wait_cyc(input int c);
        repeat (c) @(posedge mclk);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #2_000_000;
        err_count++;
        wrap_up;
    end
    initial begin
        wait_cyc(20);
        rst_b <= 1;
        wait_cyc(1);
        rd_reg(RSP_OFS_CTRL);
        chk(rd, 32'h0000_0001);
        chk(rst_pin_oe_n, 1'b0);
        foreach (rows[i]) begin
            vcc_above_pf <= rows[i][3];
            vcc_above_bat <= rows[i][2];
            wait_cyc(6);
            chk({on_backup, nv_access_en}, rows[i][1:0]);
            chk(rtc_access_en, 1'b1);
            if (!rows[i][3]) chk(rst_pin_oe_n, 1'b0);
        end
        wait_cyc(40);
        chk(rst_pin_oe_n, 1'b1);
        $display("supply test done");
        wr(RSP_OFS_CTRL, 32'h09);
        vcc_above_pf <= 0;
        wait_cyc(6);
        vcc_above_pf <= 1;
        wait_cyc(6);
        chk(rst_pin_oe_n, 1'b1);
        wr(RSP_OFS_ICLR, 32'h1F);
        wr(RSP_OFS_IEN, 32'h08);
        press <= 1;
        wait_cyc(6);
        chk({rst_pin_oe_n, irq}, 2'b01);
        wait_cyc(60);
        press <= 0;
        wait_cyc(10);
        chk(rst_pin_oe_n, 1'b0);
        wait_cyc(40);
        chk(rst_pin_oe_n, 1'b1);
        wr(RSP_OFS_IEN, 32'h00);
        wait_cyc(2);
        chk(irq, 1'b0);
        wr(RSP_OFS_IEN, 32'h08);
        wait_cyc(2);
        chk(irq, 1'b1);
        wr(RSP_OFS_ICLR, 32'h08);
        wait_cyc(2);
        chk(irq, 1'b0);
        $display("pushbutton test done");
        foreach (halves[i]) begin
            wr(RSP_OFS_CTRL, {i[1:0], 1'b0});
            n = 0;
            repeat (2440) begin
                @(posedge mclk);
                n += (irq_wave_oe_n !== last);
                last = irq_wave_oe_n;
            end
            chk(n >= 2440 / halves[i] - 1 &&
                n < 2443 / halves[i] + 3, 1);
        end
        wr(RSP_OFS_CTRL, 32'h11);
        alarm2_match <= 1;
        wait_cyc(1);
        alarm2_match <= 0;
        wait_cyc(3);
        chk(irq_n, 1'b1);
        alarm1_match <= 1;
        wait_cyc(1);
        alarm1_match <= 0;
        wait_cyc(3);
        chk(irq_n, 1'b0);
        $display("output pin test done");
        wr(RSP_OFS_AGING, 32'h02);
        wr(RSP_OFS_CTRL, 32'h41);
        wait_cyc(15);
        chk(cap_sel, 8'h81);
        wr(RSP_OFS_AGING, 32'h05);
        wait_cyc(60);
        chk(cap_sel, 8'h81);
        temp_value <= 8'sh1D;
        wait_cyc(60);
        rd_reg(RSP_OFS_CAP);
        chk(rd[7:0], 8'h84);
        rd_reg(8'h40);
        chk(rsp, RSP_RESP_SLVERR);
        s_axi_wstrb <= 4'h0;
        wr(RSP_OFS_AGING, 32'h7F);
        chk(rsp, RSP_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd_reg(RSP_OFS_AGING);
        chk(rd, 32'h05);
        wr(8'h40, 32'h00);
        chk(rsp, RSP_RESP_SLVERR);
        $display("compensation test done");
        rst_b <= 0;
        wait_cyc(2);
        chk({conv_start, rst_pin_oe_n, irq_wave_oe_n, irq, rst_pin_out,
            irq_wave_out_n}, 6'b101000);
        chk(cap_sel, RSP_CAP_RST);
        rst_b <= 1;
        wait_cyc(2);
        chk(conv_start, 1'b0);
        $display("reset test done");
        wrap_up;
    end
endmodule
